//--- include/bfsd_pkg.sv
// Shared constants, register layout and carrier types of the boot flash select decoder.
`default_nettype none
package bfsd_pkg;

   // Register bus widths.
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int STRB_W = DATA_W / 8;
   localparam int WORD_LSB = 2;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [ADDR_W-WORD_LSB-1:0] CTRL_INDEX = 10'h042;
   localparam logic [ADDR_W-WORD_LSB-1:0] STAT_INDEX = 10'h043;

   // Control register layout.
   localparam int CTRL_W = 16;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
   localparam logic [CTRL_W-1:0] CTRL_WRITE_MASK = 16'h87FF;
   localparam int WRITE_PERMIT_BIT = 15;
   localparam int BOOT_SIZE_BIT = 0;
   localparam int REGION_LO = 1;
   localparam int REGION_HI = 10;
   localparam int HIT_W = 11;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Status register layout.
   localparam int STAT_HIT_LSB = 0;
   localparam int STAT_WRITE_BIT = 16;
   localparam int STAT_ACTIVE_BIT = 17;
   localparam int STAT_COUNT_LSB = 24;
   localparam int COUNT_W = 8;

   // Selectable windows, indexed by their enable bit in the control register.
   localparam logic [REGION_HI:REGION_LO][31:0] REGION_BASE = {
      32'hFFC00000, 32'hFFD00000, 32'hFFE00000, 32'hFFE80000, 32'hFFF00000,
      32'hFFF40000, 32'hFFF80000, 32'hFFFA0000, 32'hFFFC0000, 32'h000C0000};
   localparam logic [REGION_HI:REGION_LO][31:0] REGION_MASK = {
      32'hFFF00000, 32'hFFF00000, 32'hFFF80000, 32'hFFF80000, 32'hFFFC0000,
      32'hFFFC0000, 32'hFFFE0000, 32'hFFFE0000, 32'hFFFE0000, 32'hFFFE0000};

   // Boot windows, decoded always; the size bit picks the small or large pair.
   localparam logic [31:0] BOOT_LOW_SMALL = 32'h000F0000;
   localparam logic [31:0] BOOT_HIGH_SMALL = 32'hFFFF0000;
   localparam logic [31:0] BOOT_MASK_SMALL = 32'hFFFF0000;
   localparam logic [31:0] BOOT_LOW_LARGE = 32'h000E0000;
   localparam logic [31:0] BOOT_HIGH_LARGE = 32'hFFFE0000;
   localparam logic [31:0] BOOT_MASK_LARGE = 32'hFFFE0000;

   // One host memory cycle as seen by the decoder.
   typedef struct packed {
      logic [31:0] addr;
      logic read;
      logic write;
   } bfsd_mem_cycle_t;

   // Running select count, whether the last cycle was selected, and the state of the most recent selected cycle, shown in the status register.
   typedef struct packed {
      logic [COUNT_W-1:0] count;
      logic active;
      logic last_write;
      logic [HIT_W-1:0] hit_map;
   } bfsd_status_t;

   // True when the address lies inside the aligned window base/mask.
   function automatic logic window_match(input logic [31:0] addr, input logic [31:0] base,
                                         input logic [31:0] mask);
      window_match = ((addr & mask) == base);
   endfunction

endpackage
`default_nettype wire

//--- hdl/bfsd_region_decode.sv
// Combinational address window decoder for the flash chip select.
`timescale 1ns/100ps
`default_nettype none

module bfsd_region_decode (
   input wire logic [31:0] addr, // Host memory address.
   input wire logic [bfsd_pkg::HIT_W-1:0] region_ctrl, // Region enables and boot size bit.
   output logic [bfsd_pkg::HIT_W-1:0] hit_map // One bit per window that matches.
);

   // Each enabled window contributes its own hit bit, so software can see which one fired.
   always_comb begin
      hit_map = '0;
      for (int i = bfsd_pkg::REGION_LO; i <= bfsd_pkg::REGION_HI; i++) begin
         // R3 R4 R5 R6 R7 R8 R9 R10 R11 R12 window enables.
         hit_map[i] = region_ctrl[i] &
                      bfsd_pkg::window_match(addr, bfsd_pkg::REGION_BASE[i],
                                             bfsd_pkg::REGION_MASK[i]);
      end
      // R13 boot window size.
      if (region_ctrl[bfsd_pkg::BOOT_SIZE_BIT]) begin
         // The large pair also covers the small pair, so no gap opens when it grows.
         hit_map[bfsd_pkg::BOOT_SIZE_BIT] =
            bfsd_pkg::window_match(addr, bfsd_pkg::BOOT_LOW_LARGE, bfsd_pkg::BOOT_MASK_LARGE) |
            bfsd_pkg::window_match(addr, bfsd_pkg::BOOT_HIGH_LARGE, bfsd_pkg::BOOT_MASK_LARGE);
      end else begin
         hit_map[bfsd_pkg::BOOT_SIZE_BIT] =
            bfsd_pkg::window_match(addr, bfsd_pkg::BOOT_LOW_SMALL, bfsd_pkg::BOOT_MASK_SMALL) |
            bfsd_pkg::window_match(addr, bfsd_pkg::BOOT_HIGH_SMALL, bfsd_pkg::BOOT_MASK_SMALL);
      end
   end

endmodule
`default_nettype wire

//--- hdl/bfsd_top.sv
// Boot flash chip select decoder with its control register on an AXI4-Lite slave.
// Operation
// R1 - Write permit clear: select on reads only.
// R2 - Write permit set: select reads and writes.
// R3 - Bit 10 enables the FFC00000h megabyte.
// R4 - Bit 9 enables the FFD00000h megabyte.
// R5 - Bit 8 enables FFE00000h half megabyte.
// R6 - Bit 7 enables FFE80000h half megabyte.
// R7 - Bit 6 enables FFF00000h 256 kilobytes.
// R8 - Bit 5 enables FFF40000h 256 kilobytes.
// R9 - Bit 4 enables FFF80000h 128 kilobytes.
// R10 - Bit 3 enables FFFA0000h 128 kilobytes.
// R11 - Bit 2 enables FFFC0000h 128 kilobytes.
// R12 - Bit 1 enables legacy C0000h-DFFFFh window.
// R13 - Bit 0 picks 64K or 128K boot.
// R14 - Select low on qualifying hit, else high.
// R15 - Reserved bits 14-11 read zero, ignore writes.
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module bfsd_top (
   input wire logic clk,
   input wire logic rst_n,
   // Host memory cycle, sampled every clock.
   input wire bfsd_pkg::bfsd_mem_cycle_t mem_cycle,
   // Active low chip select to the flash.
   output logic flash_select_n,
   // AXI4-Lite write address channel.
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [bfsd_pkg::ADDR_W-1:0] s_axi_awaddr,
   // AXI4-Lite write data channel.
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [bfsd_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [bfsd_pkg::STRB_W-1:0] s_axi_wstrb,
   // AXI4-Lite write response channel.
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read address channel.
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [bfsd_pkg::ADDR_W-1:0] s_axi_araddr,
   // AXI4-Lite read data channel.
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [bfsd_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp
);

   // Write side states: gather address and data, then answer.
   typedef enum logic {BFSD_WR_COLLECT, BFSD_WR_RESP} bfsd_wr_state_t;
   // Read side states: wait for an address, then answer.
   typedef enum logic {BFSD_RD_IDLE, BFSD_RD_RESP} bfsd_rd_state_t;

   // Word index of a byte address on the bus.
   function automatic logic [bfsd_pkg::ADDR_W-bfsd_pkg::WORD_LSB-1:0] word_index(
      input logic [bfsd_pkg::ADDR_W-1:0] byte_addr);
      word_index = byte_addr[bfsd_pkg::ADDR_W-1:bfsd_pkg::WORD_LSB];
   endfunction

   // Control register and its next value.
   logic [bfsd_pkg::CTRL_W-1:0] ctrl_reg;
   logic [bfsd_pkg::CTRL_W-1:0] ctrl_next;
   // Status of the decoder, shown to software.
   bfsd_pkg::bfsd_status_t status_reg;
   bfsd_pkg::bfsd_status_t status_next;
   // Registered chip select.
   logic flash_select_n_reg;
   logic flash_select_n_next;

   // Write channel state.
   bfsd_wr_state_t wr_state_reg;
   bfsd_wr_state_t wr_state_next;
   logic aw_have_reg; // Write address held.
   logic aw_have_next;
   logic w_have_reg; // Write data held.
   logic w_have_next;
   logic [bfsd_pkg::ADDR_W-1:0] aw_addr_reg;
   logic [bfsd_pkg::ADDR_W-1:0] aw_addr_next;
   logic [bfsd_pkg::DATA_W-1:0] w_data_reg;
   logic [bfsd_pkg::DATA_W-1:0] w_data_next;
   logic [bfsd_pkg::STRB_W-1:0] w_strb_reg;
   logic [bfsd_pkg::STRB_W-1:0] w_strb_next;
   logic awready_reg;
   logic awready_next;
   logic wready_reg;
   logic wready_next;
   logic bvalid_reg;
   logic bvalid_next;
   logic [1:0] bresp_reg;
   logic [1:0] bresp_next;

   // Read channel state.
   bfsd_rd_state_t rd_state_reg;
   bfsd_rd_state_t rd_state_next;
   logic arready_reg;
   logic arready_next;
   logic rvalid_reg;
   logic rvalid_next;
   logic [bfsd_pkg::DATA_W-1:0] rdata_reg;
   logic [bfsd_pkg::DATA_W-1:0] rdata_next;
   logic [1:0] rresp_reg;
   logic [1:0] rresp_next;

   // Windows that the current memory address hits, after the enables.
   logic [bfsd_pkg::HIT_W-1:0] hit_map;

   // The decoder only needs the region enables and the boot size bit.
   bfsd_region_decode u_decode (
      .addr(mem_cycle.addr),
      .region_ctrl(ctrl_reg[bfsd_pkg::HIT_W-1:0]),
      .hit_map(hit_map)
   );

   // Chip select and status next values.
   always_comb begin
      logic qualify;
      logic selected;
      qualify = 1'b0;
      selected = 1'b0;
      status_next = status_reg;
      // R1 reads always qualify.
      // R2 writes qualify under permit.
      qualify = mem_cycle.read |
                (mem_cycle.write & ctrl_reg[bfsd_pkg::WRITE_PERMIT_BIT]);
      // R14 select on any hit.
      selected = qualify & (|hit_map);
      flash_select_n_next = ~selected;
      status_next.active = selected;
      if (selected) begin
         // Keep the windows of the last selected cycle for debug reads.
         status_next.hit_map = hit_map;
         status_next.last_write = mem_cycle.write & ~mem_cycle.read;
         // The counter wraps; it only shows that selects are happening.
         status_next.count = status_reg.count + (bfsd_pkg::COUNT_W)'(1);
      end
   end

   // Chip select and status registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_select_n_reg <= 1'b1;
         status_reg <= '0;
      end else begin
         flash_select_n_reg <= flash_select_n_next;
         status_reg <= status_next;
      end
   end

   // Write channel and control register next values.
   always_comb begin
      logic aw_fire;
      logic w_fire;
      logic [bfsd_pkg::CTRL_W-1:0] merged;
      aw_fire = s_axi_awvalid & awready_reg;
      w_fire = s_axi_wvalid & wready_reg;
      merged = ctrl_reg;
      wr_state_next = wr_state_reg;
      aw_have_next = aw_have_reg | aw_fire;
      w_have_next = w_have_reg | w_fire;
      aw_addr_next = aw_fire ? s_axi_awaddr : aw_addr_reg;
      w_data_next = w_fire ? s_axi_wdata : w_data_reg;
      w_strb_next = w_fire ? s_axi_wstrb : w_strb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      ctrl_next = ctrl_reg;
      case (wr_state_reg)
         BFSD_WR_COLLECT: begin
            // Commit only once both halves are held, in whatever order they came.
            if (aw_have_reg && w_have_reg) begin
               if (word_index(aw_addr_reg) == bfsd_pkg::CTRL_INDEX) begin
                  // Only the two low byte lanes carry the 16-bit register.
                  for (int b = 0; b < bfsd_pkg::CTRL_W / 8; b++) begin
                     if (w_strb_reg[b]) begin
                        merged[b*8 +: 8] = w_data_reg[b*8 +: 8];
                     end
                  end
                  // R15 reserved bits stay zero.
                  ctrl_next = merged & bfsd_pkg::CTRL_WRITE_MASK;
                  bresp_next = bfsd_pkg::RESP_OKAY;
               end else if (word_index(aw_addr_reg) == bfsd_pkg::STAT_INDEX) begin
                  // Status is read only; a write is accepted and dropped.
                  bresp_next = bfsd_pkg::RESP_OKAY;
               end else begin
                  // Nothing lives here.
                  bresp_next = bfsd_pkg::RESP_SLVERR;
               end
               aw_have_next = 1'b0;
               w_have_next = 1'b0;
               bvalid_next = 1'b1;
               wr_state_next = BFSD_WR_RESP;
            end
         end
         BFSD_WR_RESP: begin
            // Hold the answer until the master takes it.
            if (s_axi_bready) begin
               bvalid_next = 1'b0;
               wr_state_next = BFSD_WR_COLLECT;
            end
         end
         default: begin
            wr_state_next = BFSD_WR_COLLECT;
            bvalid_next = 1'b0;
         end
      endcase
      // Each half is refused while it is held or an answer is pending.
      awready_next = ~aw_have_next & (wr_state_next == BFSD_WR_COLLECT);
      wready_next = ~w_have_next & (wr_state_next == BFSD_WR_COLLECT);
   end

   // Write channel and control registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_state_reg <= BFSD_WR_COLLECT;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= bfsd_pkg::RESP_OKAY;
         ctrl_reg <= bfsd_pkg::CTRL_RESET;
      end else begin
         wr_state_reg <= wr_state_next;
         aw_have_reg <= aw_have_next;
         w_have_reg <= w_have_next;
         aw_addr_reg <= aw_addr_next;
         w_data_reg <= w_data_next;
         w_strb_reg <= w_strb_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         ctrl_reg <= ctrl_next;
      end
   end

   // Read channel next values.
   always_comb begin
      rd_state_next = rd_state_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      arready_next = arready_reg;
      case (rd_state_reg)
         BFSD_RD_IDLE: begin
            arready_next = 1'b1;
            if (s_axi_arvalid && arready_reg) begin
               // Data is captured at the address edge, so the answer shows the
               // state of that moment even if a later cycle changes it.
               rdata_next = '0;
               rresp_next = bfsd_pkg::RESP_OKAY;
               if (word_index(s_axi_araddr) == bfsd_pkg::CTRL_INDEX) begin
                  // R15 reserved bits read zero.
                  rdata_next[bfsd_pkg::CTRL_W-1:0] = ctrl_reg & bfsd_pkg::CTRL_WRITE_MASK;
               end else if (word_index(s_axi_araddr) == bfsd_pkg::STAT_INDEX) begin
                  rdata_next[bfsd_pkg::STAT_HIT_LSB +: bfsd_pkg::HIT_W] = status_reg.hit_map;
                  rdata_next[bfsd_pkg::STAT_WRITE_BIT] = status_reg.last_write;
                  rdata_next[bfsd_pkg::STAT_ACTIVE_BIT] = status_reg.active;
                  rdata_next[bfsd_pkg::STAT_COUNT_LSB +: bfsd_pkg::COUNT_W] = status_reg.count;
               end else begin
                  rresp_next = bfsd_pkg::RESP_SLVERR;
               end
               rvalid_next = 1'b1;
               arready_next = 1'b0;
               rd_state_next = BFSD_RD_RESP;
            end
         end
         BFSD_RD_RESP: begin
            if (s_axi_rready) begin
               rvalid_next = 1'b0;
               arready_next = 1'b1;
               rd_state_next = BFSD_RD_IDLE;
            end
         end
         default: begin
            rd_state_next = BFSD_RD_IDLE;
            rvalid_next = 1'b0;
            arready_next = 1'b0;
         end
      endcase
   end

   // Read channel registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_state_reg <= BFSD_RD_IDLE;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= bfsd_pkg::RESP_OKAY;
      end else begin
         rd_state_reg <= rd_state_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   // Every output comes straight from its flip-flop.
   assign flash_select_n = flash_select_n_reg;
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

endmodule
`default_nettype wire

//--- verification/bfsd_top_sva.sv
// Concurrent checks on the ports of the boot flash select decoder.
`timescale 1ns/100ps
`default_nettype none
module bfsd_top_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire bfsd_pkg::bfsd_mem_cycle_t mem_cycle,
   input wire logic flash_select_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp
);
   // One clock domain, so clocking and reset are given once.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Address and data offered and taken at the same edge.
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // Response appears exactly two edges after the write is taken.
   sequence resp_late;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   chk_boot_read: assert property (mem_cycle.read && mem_cycle.addr[31:16] == 16'hFFFF
      |=> !flash_select_n) else $error("boot read not selected");
   chk_idle_high: assert property (!mem_cycle.read && !mem_cycle.write
      |=> flash_select_n) else $error("select without a cycle");
   chk_miss_high: assert property (mem_cycle.addr[31:22] != 10'h3FF
      && mem_cycle.addr[31:20] != 12'h000 |=> flash_select_n) else $error("select on miss");
   chk_legacy_miss: assert property (mem_cycle.addr[31:20] == 12'h000
      && mem_cycle.addr[19:18] != 2'b11 |=> flash_select_n) else $error("low select");
   chk_write_resp: assert property (wr_taken |=> resp_late)
      else $error("write response timing");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   chk_r_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   // The two low address bits select a byte lane, not a register, so only the word index counts.
   chk_bad_read: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr[11:2] != 10'h042 && s_axi_araddr[11:2] != 10'h043
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read answered");
   chk_busy_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while busy");
endmodule
bind bfsd_top bfsd_top_sva bfsd_top_sva_i (.clk, .rst_n, .mem_cycle, .flash_select_n,
   .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
   .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
   .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
`default_nettype wire

//--- verification/bfsd_flash_model.sv
// Behavioural flash chip on the far side of the select line.
`timescale 1ns/100ps
`default_nettype none
module bfsd_flash_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flash_select_n,
   output logic [15:0] sel_cycles
);
   // Counts the cycles in which the chip sees itself selected.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_cycles <= 16'h0000;
      end else if (!flash_select_n) begin
         sel_cycles <= sel_cycles + 16'h0001;
      end
   end
endmodule
`default_nettype wire

//--- verification/bfsd_top_tb.sv
// Self-checking bench for the boot flash select decoder.
`timescale 1ns/100ps
`default_nettype none
module bfsd_top_tb;
   logic clk, rst_n, flash_select_n;
   bfsd_pkg::bfsd_mem_cycle_t mem_cycle;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] ctl; // Bench copy of the control register.
   logic [15:0] sel_cycles;
   integer seed = 32'hB7B9D274;
   int err_count = 0;
   int total_checks = 0;
   logic [33:0] b_q[$], r_q[$]; // Expected {resp, data} notes.
   logic sel_q[$], sel_due[$]; // Expected select levels, one per driven cycle.
   bfsd_top bfsd_top_i (.clk, .rst_n, .mem_cycle, .flash_select_n, .s_axi_awvalid,
      .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
      .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
   bfsd_flash_model bfsd_flash_model_i (.clk, .rst_n, .flash_select_n, .sel_cycles);
   // A 25 ns clock.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("Checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Expected select level, worked out from the window list and the bench's control copy.
   function logic exp_sel(input logic [31:0] a, input logic r, input logic w);
      logic h;
      h = ctl[0] ? (a[31:17] == 15'h7FFF || a[31:17] == 15'h0007)
                 : (a[31:16] == 16'hFFFF || a[31:16] == 16'h000F);
      for (int i = 1; i <= 10; i++) begin
         if (ctl[i] && (a & bfsd_pkg::REGION_MASK[i]) == bfsd_pkg::REGION_BASE[i]) h = 1'b1;
      end
      return !(h && (r || (w && ctl[15])));
   endfunction
   // One memory cycle; the select answer is due one edge later.
   task mem(input logic [31:0] a, input logic r, input logic w);
      @(posedge clk);
      mem_cycle <= {a, r, w};
      sel_q.push_back(exp_sel(a, r, w));
   endtask
   // Write with address and data offered together; bready may be held back st cycles.
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e,
           input int st);
      logic a_ok;
      logic w_ok;
      b_q.push_back({e, 32'h0});
      a_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      while (!(a_ok && w_ok)) begin
         @(posedge clk);
         if (s_axi_awready && s_axi_awvalid) begin
            s_axi_awvalid <= 1'b0;
            a_ok = 1'b1;
         end
         if (s_axi_wready && s_axi_wvalid) begin
            s_axi_wvalid <= 1'b0;
            w_ok = 1'b1;
         end
      end
      repeat (st) @(posedge clk);
      s_axi_bready <= 1'b1;
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   // Read; rready is raised st cycles after the address is taken.
   task rd(input logic [11:0] a, input logic [33:0] e, input int st);
      r_q.push_back(e);
      @(posedge clk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      repeat (st) @(posedge clk);
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   // Bus answers are taken at their handshake edge and matched against the oldest note.
   always @(posedge clk) begin
      if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 32'h0}, b_q.pop_front());
      if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, r_q.pop_front());
   end
   // Select notes wait one full cycle so the registered answer has settled.
   always @(negedge clk) begin
      while (sel_due.size() > 0) check({33'h0, flash_select_n}, {33'h0, sel_due.pop_front()});
      sel_due = sel_q;
      sel_q.delete();
   end
   // Watchdog sized well above the several hundred cycles the sequence needs.
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      finish_test();
   end
   initial begin
      logic [15:0] c;
      logic [31:0] v;
      rst_n = 1'b0;
      mem_cycle = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      ctl = 16'h0000;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      mem(32'hFFFF0000, 1'b0, 1'b0);
      rd(12'h108, 34'h0, 0);
      wr(12'h108, 32'hFFFFFFFF, 4'hF, 2'h0, 2);
      ctl = 16'h87FF;
      rd(12'h108, {2'h0, 32'h87FF}, 2);
      wr(12'h108, 32'h0, 4'h1, 2'h0, 0);
      ctl = 16'h8700;
      rd(12'h108, {2'h0, 32'h8700}, 0);
      wr(12'h200, 32'hFFFFFFFF, 4'hF, 2'h2, 0);
      rd(12'h200, {2'h2, 32'h0}, 1);
      wr(12'h10C, 32'hFFFFFFFF, 4'hF, 2'h0, 0);
      rd(12'h108, {2'h0, 32'h8700}, 0);
      // each enable alone, then random mixes.
      for (int k = 0; k < 24; k++) begin
         v = $random(seed);
         c = (k < 11) ? ((16'h0001 << k) | {v[2], 15'h0}) : v[31:16];
         wr(12'h108, {16'h0, c}, 4'hF, 2'h0, k % 3);
         ctl = c & 16'h87FF;
         for (int j = 1; j <= 10; j++) begin
            v = $random(seed);
            mem(bfsd_pkg::REGION_BASE[j] | (v & ~bfsd_pkg::REGION_MASK[j]), v[0], v[1]);
         end
         v = $random(seed);
         mem({16'hFFFE, v[15:0]}, v[0], v[1]);
         mem({16'h000E, v[15:0]}, v[1], v[0]);
         mem({16'h000F, v[15:0]}, 1'b1, 1'b0);
         mem({16'hFFFF, v[15:0]}, 1'b0, 1'b1);
         mem(32'h000BFFFF, 1'b1, 1'b0);
         mem(v, 1'b1, v[3]);
         mem(32'h0, 1'b0, 1'b0);
      end
      repeat (3) @(posedge clk);
      check({33'h0, sel_cycles != 16'h0}, {33'h0, 1'b1});
      finish_test();
   end
endmodule
`default_nettype wire
